// [include/uat_pkg.sv]
// Constants, types and register map of the asynchronous serial transmitter
package uat_pkg;

    // Register map, one byte per address
    localparam logic [7:0] ADDR_TX_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PERIPHERAL_FLAG = 8'h01;
    localparam logic [7:0] ADDR_PERIPHERAL_ENABLE = 8'h02;
    localparam logic [7:0] ADDR_TX_HOLDING_BUFFER = 8'h03;
    localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h04;

    // Field positions in tx_control_status
    localparam int CTRL_NINTH_BIT_POS = 0;
    localparam int CTRL_SHIFT_EMPTY_POS = 1;
    localparam int CTRL_HIGH_SPEED_POS = 2;
    localparam int CTRL_SYNC_POS = 4;
    localparam int CTRL_ENABLE_POS = 5;
    localparam int CTRL_NINE_BIT_POS = 6;

    // Buffer-empty flag and its interrupt enable
    localparam int FLAG_BUF_EMPTY_POS = 4;
    localparam int IRQ_EN_BUF_EMPTY_POS = 4;

    // Reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BAUD_DIVISOR_RST = 8'h00;
    localparam logic [8:0] SHIFT_RST = 9'h000;

    // Baud ticks per bit, minus one
    localparam logic [5:0] PRESCALE_X16_LAST = 6'h0F;
    localparam logic [5:0] PRESCALE_X64_LAST = 6'h3F;
    localparam logic [5:0] PRESCALE_RST = 6'h00;

    // Index of the last data bit of a frame
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [3:0] LAST_BIT_NINE = 4'h8;
    localparam logic [3:0] BIT_COUNT_RST = 4'h0;
    localparam logic [3:0] BIT_COUNT_STEP = 4'h1;
    localparam logic [7:0] BAUD_COUNT_STEP = 8'h01;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT,
        TX_START,
        TX_DATA,
        TX_STOP
    } uat_tx_state_e;

    typedef struct packed {
        logic nineBitSelect;
        logic transmitEnable;
        logic syncSelect;
        logic highSpeedSelect;
        logic ninthBitValue;
    } uat_ctrl_s;

    localparam uat_ctrl_s CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uat_bus_s;

endpackage

// [rtl/uat_async_tx.sv]
// Asynchronous serial transmitter with baud generator and register port
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - Frame is NRZ: one start bit, eight or nine data bits, one stop bit.
// - Data bits leave least significant bit first.
// - Transmit side only; a separate receiver would share frame format and baud rate.
// - Bit timing comes from a baud generator holding an 8-bit divisor.
// - High-speed select picks 16 or 64 baud ticks per bit.
// - No hardware parity; software parity goes out as ninth bit.
// - Sleep halts all asynchronous activity.
// - Asynchronous mode only while synchronous select is clear.
// - Shift register reloads from buffer right after the stop bit, if data waits.
// - Buffer-empty flag sets regardless of its interrupt enable, which gates only irq.
// - Software cannot clear buffer-empty flag; only a buffer write clears it.
// - Read-only shift-empty status, set while shift register empty, no irq.
// - Shift register has no register address.
// - Setting transmit enable sets the buffer-empty flag.
// - Shifting starts only with enable, buffered data and a shift clock.
// - Writing buffer before enabling still starts transmission.
// - First write moves at once to empty shift register, allowing back to back.
// - Clearing enable aborts the frame, resets transmitter, releases pin.
// - Nine-bit select sends nine bits, ninth from ninth-bit holder.
module uat_async_tx (
    input wire logic clk,
    input wire logic nrst,
    input wire uat_pkg::uat_bus_s busReq,
    output logic [7:0] busRdata,
    input wire logic sleepMode,
    output logic serialOut,
    output logic serialOutEn,
    output logic txBufferEmptyIrq
);

    uat_pkg::uat_ctrl_s ctrl_reg;
    uat_pkg::uat_tx_state_e state_reg;
    uat_pkg::uat_tx_state_e state_next;
    logic [7:0] holdData_reg;
    logic holdFull_reg;
    logic holdFull_next;
    logic bufEmptyFlag_reg;
    logic bufEmptyFlag_next;
    logic bufEmptyIrqEn_reg;
    logic [7:0] baudDivisor_reg;
    logic [7:0] baudCnt_reg;
    logic [7:0] baudCnt_next;
    logic [5:0] prescale_reg;
    logic [5:0] prescale_next;
    logic [8:0] shift_reg;
    logic [8:0] shift_next;
    logic [3:0] bitCnt_reg;
    logic [3:0] bitCnt_next;
    logic [3:0] lastBit_reg;
    logic [3:0] lastBit_next;
    logic line_reg;
    logic line_next;
    logic [7:0] rdata_reg;
    logic loadShift;

    // Address decode
    wire logic wrCtrl = busReq.wr && (busReq.addr == uat_pkg::ADDR_TX_CONTROL_STATUS);
    wire logic wrIrqEn = busReq.wr && (busReq.addr == uat_pkg::ADDR_PERIPHERAL_ENABLE);
    wire logic wrHold = busReq.wr && (busReq.addr == uat_pkg::ADDR_TX_HOLDING_BUFFER);
    wire logic wrDivisor = busReq.wr && (busReq.addr == uat_pkg::ADDR_BAUD_DIVISOR);

    // Transmitter alive only in asynchronous mode with enable set
    wire logic active = ctrl_reg.transmitEnable && !ctrl_reg.syncSelect;
    wire logic run = active && !sleepMode;
    wire logic enableRise = wrCtrl && busReq.wdata[uat_pkg::CTRL_ENABLE_POS]
        && !ctrl_reg.transmitEnable;

    // Baud generator and bit prescaler
    wire logic baudTick = run && (baudCnt_reg == uat_pkg::BYTE_ZERO);
    wire logic [5:0] prescaleLast = ctrl_reg.highSpeedSelect ? uat_pkg::PRESCALE_X16_LAST
        : uat_pkg::PRESCALE_X64_LAST;
    wire logic bitTick = baudTick && (prescale_reg == prescaleLast);
    wire logic shiftEmpty = (state_reg == uat_pkg::TX_IDLE);
    wire logic canLoad = holdFull_reg && !wrHold;

    // Read mux; the shift register has no address
    wire logic [7:0] ctrlRead = {1'b0, ctrl_reg.nineBitSelect, ctrl_reg.transmitEnable,
        ctrl_reg.syncSelect, 1'b0, ctrl_reg.highSpeedSelect, shiftEmpty,
        ctrl_reg.ninthBitValue};
    wire logic [7:0] flagRead = {3'b000, bufEmptyFlag_reg, 4'b0000};
    wire logic [7:0] irqEnRead = {3'b000, bufEmptyIrqEn_reg, 4'b0000};
    wire logic [7:0] readMux =
        (busReq.addr == uat_pkg::ADDR_TX_CONTROL_STATUS) ? ctrlRead :
        (busReq.addr == uat_pkg::ADDR_PERIPHERAL_FLAG) ? flagRead :
        (busReq.addr == uat_pkg::ADDR_PERIPHERAL_ENABLE) ? irqEnRead :
        (busReq.addr == uat_pkg::ADDR_TX_HOLDING_BUFFER) ? holdData_reg :
        (busReq.addr == uat_pkg::ADDR_BAUD_DIVISOR) ? baudDivisor_reg :
        uat_pkg::BYTE_ZERO;

    // Baud counter reloads divisor on expiry and while inactive; prescaler cleared while inactive
    always_comb begin
        baudCnt_next = baudCnt_reg;
        prescale_next = prescale_reg;
        if (!active) begin
            baudCnt_next = baudDivisor_reg;
            prescale_next = uat_pkg::PRESCALE_RST;
        end else if (baudTick) begin
            baudCnt_next = baudDivisor_reg;
            prescale_next = (prescale_reg == prescaleLast) ? uat_pkg::PRESCALE_RST
                : prescale_reg + 6'h01;
        end else if (run) begin
            baudCnt_next = baudCnt_reg - uat_pkg::BAUD_COUNT_STEP;
        end
    end

    // Transmit sequencer
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bitCnt_next = bitCnt_reg;
        lastBit_next = lastBit_reg;
        loadShift = 1'b0;
        if (!active) begin
            state_next = uat_pkg::TX_IDLE;
            bitCnt_next = uat_pkg::BIT_COUNT_RST;
        end else if (run) begin
            case (state_reg)
                uat_pkg::TX_IDLE: begin
                    if (canLoad) begin
                        loadShift = 1'b1;
                        state_next = uat_pkg::TX_WAIT;
                    end
                end
                uat_pkg::TX_WAIT: begin
                    if (bitTick) begin
                        state_next = uat_pkg::TX_START;
                    end
                end
                uat_pkg::TX_START: begin
                    if (bitTick) begin
                        state_next = uat_pkg::TX_DATA;
                        bitCnt_next = uat_pkg::BIT_COUNT_RST;
                    end
                end
                uat_pkg::TX_DATA: begin
                    if (bitTick) begin
                        shift_next = {1'b0, shift_reg[8:1]};
                        if (bitCnt_reg == lastBit_reg) begin
                            state_next = uat_pkg::TX_STOP;
                        end else begin
                            bitCnt_next = bitCnt_reg + uat_pkg::BIT_COUNT_STEP;
                        end
                    end
                end
                uat_pkg::TX_STOP: begin
                    if (bitTick) begin
                        if (canLoad) begin
                            loadShift = 1'b1;
                            state_next = uat_pkg::TX_START;
                        end else begin
                            state_next = uat_pkg::TX_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = uat_pkg::TX_IDLE;
                end
            endcase
        end
        if (loadShift) begin
            // Ninth bit sampled from the holder at the moment of transfer
            shift_next = {ctrl_reg.ninthBitValue, holdData_reg};
            lastBit_next = ctrl_reg.nineBitSelect ? uat_pkg::LAST_BIT_NINE
                : uat_pkg::LAST_BIT_EIGHT;
        end
    end

    // Line level follows the next state so it lines up with the state register
    always_comb begin
        case (state_next)
            uat_pkg::TX_START: line_next = 1'b0;
            uat_pkg::TX_DATA: line_next = shift_next[0];
            default: line_next = 1'b1;
        endcase
    end

    // Buffer occupancy and its flag; a write never coincides with a transfer
    assign holdFull_next = wrHold ? 1'b1 : (loadShift ? 1'b0 : holdFull_reg);
    assign bufEmptyFlag_next = (loadShift || enableRise) ? 1'b1
        : (wrHold ? 1'b0 : bufEmptyFlag_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= uat_pkg::CTRL_RST;
            bufEmptyIrqEn_reg <= 1'b0;
            baudDivisor_reg <= uat_pkg::BAUD_DIVISOR_RST;
            holdData_reg <= uat_pkg::BYTE_ZERO;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= '{busReq.wdata[uat_pkg::CTRL_NINE_BIT_POS],
                    busReq.wdata[uat_pkg::CTRL_ENABLE_POS],
                    busReq.wdata[uat_pkg::CTRL_SYNC_POS],
                    busReq.wdata[uat_pkg::CTRL_HIGH_SPEED_POS],
                    busReq.wdata[uat_pkg::CTRL_NINTH_BIT_POS]};
            end
            if (wrIrqEn) begin
                bufEmptyIrqEn_reg <= busReq.wdata[uat_pkg::IRQ_EN_BUF_EMPTY_POS];
            end
            if (wrDivisor) begin
                baudDivisor_reg <= busReq.wdata;
            end
            if (wrHold) begin
                holdData_reg <= busReq.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= uat_pkg::TX_IDLE;
            shift_reg <= uat_pkg::SHIFT_RST;
            bitCnt_reg <= uat_pkg::BIT_COUNT_RST;
            lastBit_reg <= uat_pkg::LAST_BIT_EIGHT;
            line_reg <= 1'b1;
            baudCnt_reg <= uat_pkg::BAUD_DIVISOR_RST;
            prescale_reg <= uat_pkg::PRESCALE_RST;
            holdFull_reg <= 1'b0;
            bufEmptyFlag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            lastBit_reg <= lastBit_next;
            line_reg <= line_next;
            baudCnt_reg <= baudCnt_next;
            prescale_reg <= prescale_next;
            holdFull_reg <= holdFull_next;
            bufEmptyFlag_reg <= bufEmptyFlag_next;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= uat_pkg::BYTE_ZERO;
        end else begin
            rdata_reg <= busReq.rd ? readMux : uat_pkg::BYTE_ZERO;
        end
    end

    assign busRdata = rdata_reg;
    assign serialOut = line_reg;
    assign serialOutEn = active;
    assign txBufferEmptyIrq = bufEmptyFlag_reg && bufEmptyIrqEn_reg;
    // receiver would share baudTick and the same frame settings

    // Assertions
    property p_start_low;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_START) |-> !serialOut;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("Start bit not low");

    property p_stop_high;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_STOP || state_reg == uat_pkg::TX_IDLE) |-> serialOut;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("Stop or idle level not high");

    property p_lsb_first;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_DATA && bitTick && bitCnt_reg != lastBit_reg)
            |=> serialOut == $past(shift_reg[1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("Data bit order wrong");

    property p_flag_clear_by_write;
        @(posedge clk) disable iff (!nrst)
        $fell(bufEmptyFlag_reg) |-> $past(wrHold);
    endproperty
    a_flag_clear_by_write: assert property (p_flag_clear_by_write)
        else $error("Buffer-empty flag cleared without buffer write");

    property p_enable_sets_flag;
        @(posedge clk) disable iff (!nrst)
        $rose(ctrl_reg.transmitEnable) |-> bufEmptyFlag_reg;
    endproperty
    a_enable_sets_flag: assert property (p_enable_sets_flag)
        else $error("Enable did not set buffer-empty flag");

    property p_abort;
        @(posedge clk) disable iff (!nrst)
        !ctrl_reg.transmitEnable |-> !serialOutEn ##1 (state_reg == uat_pkg::TX_IDLE);
    endproperty
    a_abort: assert property (p_abort)
        else $error("Transmitter not reset after disable");

    property p_back_to_back;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_STOP && bitTick && canLoad && run)
            |=> (state_reg == uat_pkg::TX_START) && bufEmptyFlag_reg && !holdFull_reg;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("No immediate reload after stop bit");

    property p_shift_empty_status;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_STOP && bitTick && !canLoad && run)
            |=> ctrlRead[uat_pkg::CTRL_SHIFT_EMPTY_POS];
    endproperty
    a_shift_empty_status: assert property (p_shift_empty_status)
        else $error("Shift-empty status not set after frame");

    property p_reload_divisor;
        @(posedge clk) disable iff (!nrst)
        baudTick |=> baudCnt_reg == $past(baudDivisor_reg);
    endproperty
    a_reload_divisor: assert property (p_reload_divisor)
        else $error("Baud generator did not reload divisor");

    property p_sleep_halts;
        @(posedge clk) disable iff (!nrst)
        (sleepMode && active) |=> $stable(state_reg) && $stable(baudCnt_reg);
    endproperty
    a_sleep_halts: assert property (p_sleep_halts)
        else $error("Transmitter advanced during sleep");

    property p_start_needs_tick;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_WAIT ##1 state_reg == uat_pkg::TX_START) |-> $past(bitTick);
    endproperty
    a_start_needs_tick: assert property (p_start_needs_tick)
        else $error("Start without shift clock");

    property p_ninth_bit;
        @(posedge clk) disable iff (!nrst)
        loadShift |=> (lastBit_reg == ($past(ctrl_reg.nineBitSelect)
            ? uat_pkg::LAST_BIT_NINE : uat_pkg::LAST_BIT_EIGHT))
            && shift_reg[8] == $past(ctrl_reg.ninthBitValue);
    endproperty
    a_ninth_bit: assert property (p_ninth_bit)
        else $error("Frame length or ninth bit wrong");

    // Baud ticks between bit ticks, counted apart from the prescaler
    logic [6:0] tickCount_reg;
    logic tickCountValid_reg;
    wire logic [6:0] tickCountLast = ctrl_reg.highSpeedSelect
        ? {1'b0, uat_pkg::PRESCALE_X16_LAST} : {1'b0, uat_pkg::PRESCALE_X64_LAST};

    // Control write mid-period leaves the count meaningless until the next bit tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickCount_reg <= 7'h00;
            tickCountValid_reg <= 1'b0;
        end else if (!active || wrCtrl) begin
            tickCount_reg <= 7'h00;
            tickCountValid_reg <= 1'b0;
        end else if (bitTick) begin
            tickCount_reg <= 7'h00;
            tickCountValid_reg <= 1'b1;
        end else if (baudTick) begin
            tickCount_reg <= tickCount_reg + 7'h01;
        end
    end

    property p_prescale;
        @(posedge clk) disable iff (!nrst)
        (bitTick && tickCountValid_reg) |-> tickCount_reg == tickCountLast;
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("Bit tick at wrong prescale count");

    property p_first_transfer;
        @(posedge clk) disable iff (!nrst)
        (state_reg == uat_pkg::TX_IDLE && canLoad && run)
            |=> (state_reg == uat_pkg::TX_WAIT) && bufEmptyFlag_reg && !holdFull_reg;
    endproperty
    a_first_transfer: assert property (p_first_transfer)
        else $error("Buffer not moved at once to empty shift register");

endmodule // uat_async_tx

// [sim/uat_async_tx_tb.sv]
// Self-checking bench of the asynchronous serial transmitter
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errCount++; \
    $display("ERROR at %0t: got %h expected %h", $time, (a), (b)); end end
module uat_async_tx_tb;
    logic clk;
    logic nrst;
    uat_pkg::uat_bus_s busReq;
    logic [7:0] busRdata;
    logic sleepMode;
    logic serialOut;
    logic serialOutEn;
    logic txBufferEmptyIrq;
    logic sawLow;
    int bitCycles;
    logic nineBits;
    int errCount = 0;
    int numChecks = 0;
    // Pull-up holds the line high while the pin is released
    wire serialLine = serialOutEn ? serialOut : 1'b1;

    uat_async_tx uat_async_tx_inst (
        .clk(clk),
        .nrst(nrst),
        .busReq(busReq),
        .busRdata(busRdata),
        .sleepMode(sleepMode),
        .serialOut(serialOut),
        .serialOutEn(serialOutEn),
        .txBufferEmptyIrq(txBufferEmptyIrq)
    );

    uat_rx_model uat_rx_model_inst (
        .clk(clk),
        .lineIn(serialLine),
        .bitCycles(bitCycles),
        .nineBits(nineBits)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic giveVerdict();
        $display("Checks %0d, errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq <= '{8'h00, 8'h00, 1'b0, 1'b0};
    endtask

    task automatic busRead(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        busReq <= '{8'h00, 8'h00, 1'b0, 1'b0};
        #1;
        `CHK(busRdata, exp)
    endtask

    task automatic waitRx(input logic [8:0] exp);
        int i;
        logic [8:0] got;
        for (i = 0; i < 4000; i++) begin
            if (uat_rx_model_inst.rxQ.size() != 0) break;
            @(posedge clk);
        end
        if (uat_rx_model_inst.rxQ.size() == 0) begin
            errCount++;
            $display("ERROR at %0t: no frame received", $time);
            giveVerdict();
        end
        got = uat_rx_model_inst.rxQ.pop_front();
        `CHK(got, exp)
    endtask

    initial begin
        nrst = 1'b0;
        busReq = '{8'h00, 8'h00, 1'b0, 1'b0};
        sleepMode = 1'b0;
        bitCycles = 16;
        nineBits = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        busRead(8'h00, 8'h02);
        busRead(8'h01, 8'h00);
        busRead(8'h07, 8'h00);
        // Enable, high speed, divisor 0
        busWrite(8'h02, 8'h10);
        busWrite(8'h00, 8'h24);
        busRead(8'h01, 8'h10);
        #1 `CHK(txBufferEmptyIrq, 1'b1)
        busWrite(8'h01, 8'h00);
        busRead(8'h01, 8'h10);
        busWrite(8'h02, 8'h00);
        #1 `CHK(txBufferEmptyIrq, 1'b0)
        busRead(8'h01, 8'h10);
        // Back-to-back characters
        busWrite(8'h03, 8'h55);
        busWrite(8'h03, 8'hA3);
        busRead(8'h01, 8'h00);
        busRead(8'h00, 8'h24);
        waitRx(9'h055);
        repeat (12) @(posedge clk);
        busRead(8'h01, 8'h10);
        waitRx(9'h0A3);
        repeat (20) @(posedge clk);
        busRead(8'h00, 8'h26);
        // Nine-bit frames, ninth bit written first
        nineBits = 1'b1;
        busWrite(8'h00, 8'h65);
        busWrite(8'h03, 8'h0F);
        waitRx(9'h10F);
        busWrite(8'h00, 8'h64);
        busWrite(8'h03, 8'hF0);
        waitRx(9'h0F0);
        nineBits = 1'b0;
        busWrite(8'h00, 8'h34);
        #1 `CHK(serialOutEn, 1'b0)
        // Abort in mid-frame
        busWrite(8'h00, 8'h24);
        busWrite(8'h03, 8'h77);
        repeat (60) @(posedge clk);
        busWrite(8'h00, 8'h04);
        #1 `CHK(serialOutEn, 1'b0)
        busRead(8'h00, 8'h06);
        repeat (200) @(posedge clk);
        uat_rx_model_inst.rxQ.delete();
        // Sleep holds the line idle
        busWrite(8'h00, 8'h24);
        sleepMode <= 1'b1;
        busWrite(8'h03, 8'h5A);
        sawLow = 1'b0;
        repeat (300) begin
            @(posedge clk);
            if (serialOut !== 1'b1) sawLow = 1'b1;
        end
        `CHK(sawLow, 1'b0)
        sleepMode <= 1'b0;
        waitRx(9'h05A);
        // x64 prescale, divisor 1, buffer loaded before enable
        busWrite(8'h00, 8'h00);
        busWrite(8'h04, 8'h01);
        bitCycles = 128;
        busWrite(8'h03, 8'h3C);
        busWrite(8'h00, 8'h20);
        waitRx(9'h03C);
        `CHK(uat_rx_model_inst.frameErrs, 0)
        giveVerdict();
    end
endmodule // uat_async_tx_tb

// [sim/uat_rx_model.sv]
// Behavioural remote receiver watching the serial line
`timescale 1ns/1ps
module uat_rx_model (
    input wire logic clk,
    input wire logic lineIn,
    input wire logic [31:0] bitCycles,
    input wire logic nineBits
);
    logic [8:0] rxQ[$];
    int frameErrs = 0;
    logic [8:0] word;
    int n;

    always begin
        @(negedge lineIn);
        repeat (bitCycles / 2) @(posedge clk);
        if (lineIn === 1'b0) begin
            word = 9'h000;
            n = nineBits ? 9 : 8;
            for (int i = 0; i < n; i++) begin
                repeat (bitCycles) @(posedge clk);
                word[i] = lineIn;
            end
            repeat (bitCycles) @(posedge clk);
            if (lineIn !== 1'b1) begin
                frameErrs++;
            end
            rxQ.push_back(word);
        end
    end
endmodule // uat_rx_model
